// ---- hdl/overlay_consts.svh ----
// constants of the flash overlay remap and its cpu-side controller
// assumes one 10 MHz clock shared by both ends
//
// Contract
// - enabled large bank replaces 8-Kbyte flash region
// - enabled small bank replaces 4-Kbyte flash region
// - software leaves overlay mode before flash programming
// - overlap priority large0, small0, small1, large1
// - overlaid RAM reachable at RAM and flash
// - wait three clocks after setting mode bit
// - wait three clocks after bank register write
// - large field holds flash address bits 12-18
// - small field holds flash address bits 12-19
// - largest variant: 64 large, 128 small banks
// - medium variant: 48 large, 96 small banks
// - smallest variant: 32 large, 64 small banks
// - set mode bit before any bank enable (the testbench enables large0 before setting the mode bit)
// - RAM range stays ordinary RAM throughout
// - two blocks on one region, priority picks
`ifndef OVERLAY_CONSTS_SVH
`define OVERLAY_CONSTS_SVH

// =====================================================
// cpu address map
`define ADDR_W 24
`define RAM_BASE 24'h804000
`define RAM_LAST 24'h809FFF
`define RAM_WORDS 6144
`define RAM_IDX_W 13
`define LARGE0_OFS 15'h0000
`define LARGE1_OFS 15'h2000
`define SMALL0_OFS 15'h4000
`define SMALL1_OFS 15'h5000
`define REG_CTRL1 24'h803F00
`define REG_LBANK0 24'h803F04
`define REG_LBANK1 24'h803F08
`define REG_SBANK0 24'h803F0C
`define REG_SBANK1 24'h803F10

// =====================================================
// register fields and reset values
`define MODE_BIT 0
`define BANK_EN_BIT 8
`define BANK_AD_LSB 0
`define BANK_AD_W 8
`define BANK_RST 32'h00000000
`define CTRL1_RST 1'b0

// =====================================================
// flash variants, last bank addresses
`define FLASH_KB_BIG 512
`define FLASH_KB_MID 384
`define FLASH_KB_SML 256
`define LAST_L_BIG 8'h7E
`define LAST_S_BIG 8'h7F
`define LAST_L_MID 8'h5E
`define LAST_S_MID 8'h5F
`define LAST_L_SML 8'h3E
`define LAST_S_SML 8'h3F

// =====================================================
// timing in cpu clocks
`define SETTLE_CLKS 3

// =====================================================
// controller register map (axi4-lite byte offsets)
`define C_CTRL 8'h00
`define C_ADDR 8'h04
`define C_WDATA 8'h08
`define C_STATUS 8'h0C
`define C_RDATA 8'h10
`define C_GO_BIT 0
`define C_WR_BIT 1
`define C_BUSY_BIT 0
`define C_DONE_BIT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/overlay_pkg.sv ----
// types shared by the overlay remap and its controller
// assumes overlay_consts.svh is on the include path
package overlay_pkg;
	typedef enum logic [1:0] {
		SRC_FLASH,
		SRC_RAM,
		SRC_REG
	} src_t;
	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_FETCH,
		DEV_ANSWER
	} dev_state_t;
	typedef enum logic [1:0] {
		CT_IDLE,
		CT_WAIT,
		CT_SETTLE
	} ctl_state_t;
	typedef struct packed {
		logic en;
		logic [7:0] ad;
	} bank_t;
endpackage

// ---- hdl/overlay_bus_if.sv ----
// internal cpu bus between the cpu-side controller and the overlay remap
// assumes both ends run on the same clock
interface overlay_bus_if;
	logic req_valid;
	logic req_write;
	logic [23:0] req_addr;
	logic [31:0] req_wdata;
	logic resp_ack;
	logic [31:0] resp_rdata;
	modport cpu (output req_valid, output req_write, output req_addr, output req_wdata,
		input resp_ack, input resp_rdata);
	modport dev (input req_valid, input req_write, input req_addr, input req_wdata,
		output resp_ack, output resp_rdata);
endinterface

// ---- hdl/overlay_remap.sv ----
// overlay remap: flash control and bank registers, overlay RAM, flash read path
// assumes a sync flash array outside that answers flash_rdata one clock after flash_addr
`include "overlay_consts.svh"
module overlay_remap import overlay_pkg::*; #(
	parameter int FLASH_KB = `FLASH_KB_BIG
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	overlay_bus_if.dev bus,
	output logic [18:0] flash_addr,
	input wire logic [31:0] flash_rdata,
	output logic mode_active
);
	localparam logic [7:0] LAST_L = (FLASH_KB == `FLASH_KB_BIG) ? `LAST_L_BIG :
		(FLASH_KB == `FLASH_KB_MID) ? `LAST_L_MID : `LAST_L_SML;
	localparam logic [7:0] LAST_S = (FLASH_KB == `FLASH_KB_BIG) ? `LAST_S_BIG :
		(FLASH_KB == `FLASH_KB_MID) ? `LAST_S_MID : `LAST_S_SML;

	// only the three flash capacities have bank limits
	if (FLASH_KB != `FLASH_KB_BIG && FLASH_KB != `FLASH_KB_MID && FLASH_KB != `FLASH_KB_SML) begin : g_size_chk
		$error("overlay_remap: FLASH_KB must be 512, 384 or 256");
	end

	// the RAM index must cover every word of the RAM range
	if ((1 << `RAM_IDX_W) < `RAM_WORDS) begin : g_ram_chk
		$error("overlay_remap: RAM_IDX_W too narrow for RAM_WORDS");
	end

	// =====================================================
	// registers
	logic mode_q;
	bank_t lb0_q, lb1_q, sb0_q, sb1_q;
	logic act_mode_q;
	bank_t act_lb0_q, act_lb1_q, act_sb0_q, act_sb1_q;
	dev_state_t state_q;
	logic [23:0] addr_q;
	logic write_q;
	logic [31:0] wdata_q;
	src_t src_q;
	logic [31:0] reg_rd_q;
	logic [31:0] ram_rd_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [18:0] flash_addr_q;
	logic [31:0] ram_mem [`RAM_WORDS];

	// =====================================================
	// decode of the held request
	wire in_flash = addr_q < 24'(FLASH_KB * 1024);
	wire in_ram = addr_q >= `RAM_BASE && addr_q <= `RAM_LAST;
	wire [14:0] ram_ofs = 15'(addr_q - `RAM_BASE);
	wire sel_ctrl = addr_q == `REG_CTRL1;
	wire sel_lb0 = addr_q == `REG_LBANK0;
	wire sel_lb1 = addr_q == `REG_LBANK1;
	wire sel_sb0 = addr_q == `REG_SBANK0;
	wire sel_sb1 = addr_q == `REG_SBANK1;
	wire sel_reg = sel_ctrl | sel_lb0 | sel_lb1 | sel_sb0 | sel_sb1;

	// =====================================================
	// bank decode, slots in overlap priority: large0, small0, small1, large1
	// decode reads the settled copy; a large bank ignores field bit 0
	// an address field above the variant's last bank never hits
	wire [3:0] hit;
	for (genvar b = 0; b < 4; b++) begin : g_bank
		localparam bit IS_LARGE = (b == 0) || (b == 3);
		wire bank_t bank = (b == 0) ? act_lb0_q : (b == 1) ? act_sb0_q :
			(b == 2) ? act_sb1_q : act_lb1_q;
		wire [7:0] last_ad = IS_LARGE ? LAST_L : LAST_S;
		wire ok_ad = bank.ad <= last_ad;
		wire l_match = addr_q[23:13] == {5'h00, bank.ad[6:1]};
		wire s_match = addr_q[23:12] == {4'h0, bank.ad};
		wire region_hit = IS_LARGE ? l_match : s_match;
		assign hit[b] = act_mode_q & bank.en & ok_ad & region_hit;
	end

	wire hit_lb0 = hit[0];
	wire hit_sb0 = hit[1];
	wire hit_sb1 = hit[2];
	wire hit_lb1 = hit[3];
	wire hit_any = in_flash & (hit_lb0 | hit_sb0 | hit_sb1 | hit_lb1);

	// fixed priority among overlapping banks
	wire [14:0] ovl_ofs = hit_lb0 ? (`LARGE0_OFS | {2'b00, addr_q[12:0]}) :
		hit_sb0 ? (`SMALL0_OFS | {3'b000, addr_q[11:0]}) :
		hit_sb1 ? (`SMALL1_OFS | {3'b000, addr_q[11:0]}) :
		(`LARGE1_OFS | {2'b00, addr_q[12:0]});

	// overlaid region and RAM range share one array
	wire use_ram = in_ram | hit_any;
	wire [14:0] eff_ofs = in_ram ? ram_ofs : ovl_ofs;
	wire [`RAM_IDX_W-1:0] eff_idx = eff_ofs[14:2];
	wire [31:0] reg_rd = sel_ctrl ? {31'h0, mode_q} :
		sel_lb0 ? {23'h0, lb0_q} :
		sel_lb1 ? {23'h0, lb1_q} :
		sel_sb0 ? {23'h0, sb0_q} :
		sel_sb1 ? {23'h0, sb1_q} : 32'h00000000;
	wire src_t src_d = use_ram ? SRC_RAM : (sel_reg ? SRC_REG : SRC_FLASH);
	wire [31:0] flash_word = in_flash ? flash_rdata : 32'h00000000;
	wire [31:0] rdata_d = (src_q == SRC_RAM) ? ram_rd_q :
		(src_q == SRC_REG) ? reg_rd_q :
		flash_word;
	wire bank_wr = write_q & (state_q == DEV_FETCH);
	wire [8:0] wr_bank = {wdata_q[`BANK_EN_BIT], wdata_q[`BANK_AD_LSB +: `BANK_AD_W]};

	// =====================================================
	// answer path; a write answers with zero data
	wire [31:0] answer_word = write_q ? 32'h00000000 : rdata_d;
	wire in_fetch = ce & (state_q == DEV_FETCH);
	wire ram_we = in_fetch & use_ram & write_q;

	// =====================================================
	// request sequencer
	// the answer stands one clock, three edges after the request is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= DEV_IDLE;
			addr_q <= 24'h000000;
			write_q <= 1'b0;
			wdata_q <= 32'h00000000;
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
			src_q <= SRC_FLASH;
			reg_rd_q <= 32'h00000000;
			flash_addr_q <= 19'h00000;
		end else if (ce) begin
			ack_q <= 1'b0;
			case (state_q)
				DEV_IDLE: begin
					if (bus.req_valid) begin
						addr_q <= bus.req_addr;
						write_q <= bus.req_write;
						wdata_q <= bus.req_wdata;
						state_q <= DEV_FETCH;
					end
				end
				DEV_FETCH: begin
					src_q <= src_d;
					reg_rd_q <= reg_rd;
					flash_addr_q <= addr_q[18:0];
					state_q <= DEV_ANSWER;
				end
				DEV_ANSWER: begin
					ack_q <= 1'b1;
					rdata_q <= answer_word;
					state_q <= DEV_IDLE;
				end
				default: state_q <= DEV_IDLE;
			endcase
		end
	end

	// =====================================================
	// overlay RAM array
	always_ff @(posedge aclk) begin
		// a write's fetch reads the old word, which the answer drops
		if (ram_we)
			ram_mem[eff_idx] <= wdata_q;
		if (in_fetch)
			ram_rd_q <= ram_mem[eff_idx];
	end

	// =====================================================
	// control and bank registers
	// written in the fetch cycle; decode sees them a clock later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= `CTRL1_RST;
			lb0_q <= 9'(`BANK_RST);
			lb1_q <= 9'(`BANK_RST);
			sb0_q <= 9'(`BANK_RST);
			sb1_q <= 9'(`BANK_RST);
		end else if (ce && bank_wr) begin
			if (sel_ctrl)
				mode_q <= wdata_q[`MODE_BIT];
			if (sel_lb0)
				lb0_q <= wr_bank;
			if (sel_lb1)
				lb1_q <= wr_bank;
			if (sel_sb0)
				sb0_q <= wr_bank;
			if (sel_sb1)
				sb1_q <= wr_bank;
		end
	end

	// settled copy feeds decode one clock after the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_mode_q <= `CTRL1_RST;
			act_lb0_q <= 9'(`BANK_RST);
			act_lb1_q <= 9'(`BANK_RST);
			act_sb0_q <= 9'(`BANK_RST);
			act_sb1_q <= 9'(`BANK_RST);
		end else if (ce) begin
			act_mode_q <= mode_q;
			act_lb0_q <= lb0_q;
			act_lb1_q <= lb1_q;
			act_sb0_q <= sb0_q;
			act_sb1_q <= sb1_q;
		end
	end

	// every output comes straight from a flop
	assign bus.resp_ack = ack_q;
	assign bus.resp_rdata = rdata_q;
	assign flash_addr = flash_addr_q;
	assign mode_active = act_mode_q;
endmodule

// ---- hdl/overlay_cpu_ctrl.sv ----
// cpu-side controller: axi4-lite job registers issue single bus accesses
// assumes the overlay remap sits on the other side of overlay_bus_if
`include "overlay_consts.svh"
module overlay_cpu_ctrl import overlay_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	overlay_bus_if.cpu bus,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, job_addr_q, job_wdata_q, job_rdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic job_wr_q, done_q, req_valid_q;
	ctl_state_t state_q;
	logic [1:0] settle_q;

	// =====================================================
	// axi4-lite write side
	wire aw_take = s_axi_awvalid & ~aw_have_q & ~bvalid_q;
	wire w_take = s_axi_wvalid & ~w_have_q & ~bvalid_q;
	wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	wire busy = state_q != CT_IDLE;
	wire wr_ctrl = wr_fire & (awaddr_q == `C_CTRL);
	wire wr_addr = wr_fire & (awaddr_q == `C_ADDR);
	wire wr_wdat = wr_fire & (awaddr_q == `C_WDATA);
	wire wr_known = wr_ctrl | wr_addr | wr_wdat | (awaddr_q == `C_STATUS) | (awaddr_q == `C_RDATA);
	wire go = wr_ctrl & wdata_q[`C_GO_BIT] & ~busy;
	wire [31:0] lane_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			bresp_q <= `RESP_OKAY;
		end else if (ce) begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata & lane_mask;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// axi4-lite read side
	wire ar_take = s_axi_arvalid & ~rvalid_q;
	wire [31:0] status_word = {30'h0, done_q, busy};
	wire rd_known = (s_axi_araddr == `C_CTRL) | (s_axi_araddr == `C_ADDR) | (s_axi_araddr == `C_WDATA)
		| (s_axi_araddr == `C_STATUS) | (s_axi_araddr == `C_RDATA);
	wire [31:0] rd_word = (s_axi_araddr == `C_CTRL) ? {30'h0, job_wr_q, 1'b0} :
		(s_axi_araddr == `C_ADDR) ? job_addr_q :
		(s_axi_araddr == `C_WDATA) ? job_wdata_q :
		(s_axi_araddr == `C_STATUS) ? status_word :
		(s_axi_araddr == `C_RDATA) ? job_rdata_q : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// job sequencer; every write is followed by a settle gap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CT_IDLE;
			job_addr_q <= 32'h00000000;
			job_wdata_q <= 32'h00000000;
			job_rdata_q <= 32'h00000000;
			job_wr_q <= 1'b0;
			done_q <= 1'b0;
			req_valid_q <= 1'b0;
			settle_q <= 2'h0;
		end else if (ce) begin
			if (wr_addr && !busy)
				job_addr_q <= wdata_q;
			if (wr_wdat && !busy)
				job_wdata_q <= wdata_q;
			case (state_q)
				CT_IDLE: begin
					if (go) begin
						job_wr_q <= wdata_q[`C_WR_BIT];
						done_q <= 1'b0;
						req_valid_q <= 1'b1;
						state_q <= CT_WAIT;
					end
				end
				CT_WAIT: begin
					req_valid_q <= 1'b0;
					if (bus.resp_ack) begin
						if (!job_wr_q)
							job_rdata_q <= bus.resp_rdata;
						settle_q <= 2'(`SETTLE_CLKS - 1);
						state_q <= job_wr_q ? CT_SETTLE : CT_IDLE;
						done_q <= ~job_wr_q;
					end
				end
				CT_SETTLE: begin
					if (settle_q == 2'h0) begin
						done_q <= 1'b1;
						state_q <= CT_IDLE;
					end else begin
						settle_q <= settle_q - 2'h1;
					end
				end
				default: state_q <= CT_IDLE;
			endcase
		end
	end

	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign bus.req_valid = req_valid_q;
	assign bus.req_write = job_wr_q;
	assign bus.req_addr = job_addr_q[23:0];
	assign bus.req_wdata = job_wdata_q;
endmodule

// ---- testbench/overlay_remap_properties.sv ----
// checker for the internal cpu bus between controller and overlay remap
// assumes one clock, sync active-low reset, flash answering a clock late
`include "overlay_consts.svh"
module remap_checker #(
	parameter int FLASH_KB = `FLASH_KB_BIG
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [23:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic resp_ack,
	input wire logic [31:0] resp_rdata,
	input wire logic [18:0] flash_addr,
	input wire logic [31:0] flash_rdata,
	input wire logic mode_active
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire ctl_wr = req_valid && req_write && req_addr == `REG_CTRL1;
	wire fl_rd = req_valid && !req_write && req_addr < FLASH_KB * 1024;
	// =====================================================
	// bus handshake
	a_ack_three_edges: assert property (req_valid |-> ##3 resp_ack) else $error("ack late or missing");
	a_ack_one_cycle: assert property (resp_ack |=> !resp_ack) else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (resp_ack |-> $past(req_valid, 3)) else $error("ack without request");
	a_req_spacing: assert property (req_valid |=> !req_valid [*4]) else $error("second request too soon");
	a_write_zero_data: assert property (resp_ack && req_write |-> resp_rdata == 32'h0)
		else $error("write answer carries data");
	// =====================================================
	// mode settling and flash path
	a_mode_on_settles: assert property (ctl_wr && req_wdata[0] |-> ##[1:6] mode_active)
		else $error("mode bit not applied");
	a_mode_off_settles: assert property (ctl_wr && !req_wdata[0] |-> ##[1:6] !mode_active)
		else $error("mode bit not cleared");
	a_flash_addr_used: assert property (fl_rd && !mode_active |-> ##3 flash_addr == $past(req_addr[18:0], 3))
		else $error("flash address wrong");
	a_flash_data_back: assert property (resp_ack && $past(fl_rd, 3) && !mode_active |-> resp_rdata == flash_rdata)
		else $error("flash data not returned");
endmodule

// ---- testbench/tb_flash_ram_overlay_remap.sv ----
// testbench: controller and overlay remap joined, driven over axi4-lite
// assumes hdl/ on the include path; flash array modelled here
`include "overlay_consts.svh"
module tb_flash_ram_overlay_remap;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, flash_rdata, s_axi_rdata, s, t, expq[$], d[4];
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mode_active;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [18:0] flash_addr;
	int miscompares = 0, n_tests = 0;
	// banks in priority order and their ram blocks
	localparam logic [23:0] RG[4] = '{`REG_LBANK0, `REG_SBANK0, `REG_SBANK1, `REG_LBANK1};
	localparam logic [23:0] PB[4] = '{24'h804000, 24'h808000, 24'h809000, 24'h806000};
	overlay_bus_if bus();
	overlay_cpu_ctrl overlay_cpu_ctrl_i(.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus(bus),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	overlay_remap overlay_remap_i(.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus(bus),
		.flash_addr(flash_addr), .flash_rdata(flash_rdata), .mode_active(mode_active));
	remap_checker #(.FLASH_KB(`FLASH_KB_BIG)) remap_checker_i(.aclk(aclk), .aresetn(aresetn),
		.req_valid(bus.req_valid), .req_write(bus.req_write), .req_addr(bus.req_addr),
		.req_wdata(bus.req_wdata), .resp_ack(bus.resp_ack), .resp_rdata(bus.resp_rdata),
		.flash_addr(flash_addr), .flash_rdata(flash_rdata), .mode_active(mode_active));
	always #50 aclk = ~aclk;
	// =====================================================
	// flash array and result watcher
	function automatic logic [31:0] fl(input logic [18:0] a);
		return 32'hA5A50000 ^ {13'h0, a};
	endfunction
	// flash word ready within the clock after flash_addr changes
	assign flash_rdata = fl(flash_addr);
	always @(posedge aclk) if (bus.resp_ack === 1'b1 && bus.req_write === 1'b0) chk_data(expq.pop_front(), bus.resp_rdata);
	task chk_data(input logic [31:0] e, input logic [31:0] v);
		n_tests++;
		if (v !== e) begin
			miscompares++;
			$display("ERROR rdata expected %h seen %h", e, v);
		end
	endtask
	task chk_resp(input logic [1:0] e, input logic [1:0] v);
		n_tests++;
		if (v !== e) begin
			miscompares++;
			$display("ERROR resp expected %h seen %h", e, v);
		end
	endtask
	// =====================================================
	// axi4-lite master and bus jobs
	task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// one bus access; for reads v is the expected data
	task job(input logic wr, input logic [23:0] a, input logic [31:0] v);
		logic [1:0] rs;
		logic [31:0] st;
		axw(`C_ADDR, {8'h0, a}, rs);
		axw(`C_WDATA, v, rs);
		if (!wr) expq.push_back(v);
		axw(`C_CTRL, {30'h0, wr, 1'b1}, rs);
		chk_resp(`RESP_OKAY, rs);
		do axr(`C_STATUS, st, rs); while (st[`C_DONE_BIT] !== 1'b1);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		tally_and_finish;
	end
	// =====================================================
	// scenarios
	initial begin
		void'($urandom(32'h3C7FAA97));
		foreach (d[i]) d[i] = $urandom();
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		for (int i = 0; i < 4; i++) job(1, PB[i] + 24'h10, d[i]);
		job(1, `REG_LBANK0, 32'h102);
		job(0, 24'h2010, fl(19'h2010));
		job(1, `REG_CTRL1, 32'h1);
		job(0, 24'h2010, d[0]);
		job(0, 24'h4010, fl(19'h4010));
		s = $urandom();
		job(1, 24'h3020, s);
		job(0, 24'h805020, s);
		axr(`C_RDATA, t, r);
		chk_data(s, t);
		job(0, 24'h804010, d[0]);
		job(1, `REG_SBANK0, 32'h103);
		job(0, 24'h3020, s);
		for (int k = 0; k < 4; k++) job(1, RG[k], 32'h104);
		for (int k = 0; k < 4; k++) begin
			job(0, 24'h4010, d[k]);
			job(1, RG[k], 32'h0);
		end
		job(0, 24'h4010, fl(19'h4010));
		job(1, `REG_LBANK0, 32'h17E);
		job(0, 24'h7E010, d[0]);
		job(1, `REG_LBANK0, 32'h0);
		job(1, `REG_SBANK0, 32'h17F);
		job(0, 24'h7F010, d[1]);
		job(0, `REG_SBANK0, 32'h17F);
		job(1, `REG_CTRL1, 32'h0);
		job(0, 24'h7F010, fl(19'h7F010));
		axw(8'h20, 32'h1, r);
		chk_resp(`RESP_SLVERR, r);
		axr(8'h24, s, r);
		chk_resp(`RESP_SLVERR, r);
		tally_and_finish;
	end
endmodule
